// File: fault_flag_pkg.sv
package fault_flag_pkg;

    // ****************************************
    // widths and counts
    // ****************************************
    localparam int DATA_W   = 32;
    localparam int ADR_W    = 32;
    localparam int SEL_W    = 4;
    localparam int FLAG_W   = 8;
    localparam int IDX_W    = 8;
    localparam int CH_W     = 16;
    localparam int NUM_REGS = 5;
    localparam int EVT_PER  = 4;
    localparam int EVT_W    = NUM_REGS * EVT_PER;
    localparam int BYTE_W   = 8;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [IDX_W-1:0] IDX_OPEN_EF    = 8'hA9;
    localparam logic [IDX_W-1:0] IDX_OPEN_GH    = 8'hAA;
    localparam logic [IDX_W-1:0] IDX_SHORT_AB   = 8'hAB;
    localparam logic [IDX_W-1:0] IDX_SHORT_CD   = 8'hAC;
    localparam logic [IDX_W-1:0] IDX_SHORT_EF   = 8'hAD;
    localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 8'hC0;
    localparam logic [IDX_W-1:0] IDX_EVT_MASK   = 8'hC1;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int LO_POS = 0;
    localparam int HI_POS = 4;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] RSV_MASK   = 8'hCC;
    localparam logic [EVT_W-1:0]  EVT_RESET  = 20'h00000;

    // ****************************************
    // output pairs, pair p owns channel bits 2p and 2p+1
    // ****************************************
    localparam int PAIR_A = 0;
    localparam int PAIR_C = 2;
    localparam int PAIR_E = 4;
    localparam int PAIR_G = 6;

    // slot order of the flag registers
    localparam int K_OPEN_EF  = 0;
    localparam int K_OPEN_GH  = 1;
    localparam int K_SHORT_AB = 2;
    localparam int K_SHORT_CD = 3;
    localparam int K_SHORT_EF = 4;
    localparam logic [NUM_REGS*IDX_W-1:0] REG_IDX =
        {IDX_SHORT_EF, IDX_SHORT_CD, IDX_SHORT_AB, IDX_OPEN_GH, IDX_OPEN_EF};
    localparam int REG_LO_PAIR [NUM_REGS] = '{PAIR_E, PAIR_G, PAIR_A, PAIR_C, PAIR_E};
    localparam logic [NUM_REGS-1:0] REG_IS_OPEN = 5'h03;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADR_W-1:0]  adr;
        logic [SEL_W-1:0]  sel;
        logic [DATA_W-1:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] dat;
    } wb_rsp_type;

    typedef struct packed {
        logic [CH_W-1:0] open_det;
        logic [CH_W-1:0] short_det;
    } fault_det_type;

endpackage

// File: fault_flag_regs.sv
//
// Contract
// [R1] open flag reads one exactly while fault detected
// [R2] short flag reads one exactly while fault detected
// [R3] open E/F: E in bits 1:0, F 5:4
// [R4] open G/H at AAh, G 1:0, H 5:4
// [R5] short A/B at ABh, A 1:0, B 5:4
// [R6] short C/D at ACh, C 1:0, D 5:4
// [R7] flags reset zero, reserved bits read zero
// [R8] short E/F at ADh, resets to zero
// [R9] short E/F: E bits 1:0, F 5:4
// [R10] open E/F at A9h, resets to zero
// [R11] flags read-only, writes never change them
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module fault_flag_regs
    import fault_flag_pkg::*;
#(
    parameter int BUS_ADR_W = ADR_W
)
(
    // clock and reset
    input  wire logic    clock,
    input  wire logic    rst_n,
    // wishbone slave
    input  wb_req_type    wb_req,
    output wb_rsp_type    wb_rsp,
    // diagnostic fault indications
    input  fault_det_type det,
    // interrupt
    output logic          irq
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (BUS_ADR_W != ADR_W) begin : g_bad_adr
        $error("fault_flag_regs: BUS_ADR_W must equal the bus address width");
    end

    logic [NUM_REGS-1:0][FLAG_W-1:0] flag_vec;
    logic [EVT_W-1:0]                rise_vec;
    logic [EVT_W-1:0]                status;
    logic [EVT_W-1:0]                mask;
    logic                            irq_bank;
    wb_rsp_type                      rsp_q;
    wb_rsp_type                      rsp_d;
    logic [IDX_W-1:0]                idx;
    logic                            upper_ok;
    logic                            req;
    logic                            wr_fire;
    logic [EVT_W-1:0]                wen;
    logic [DATA_W-1:0]               rd_d;

    // ****************************************
    // flag registers
    // ****************************************
    for (genvar k = 0; k < NUM_REGS; k++) begin : g_reg
        localparam int LO = REG_LO_PAIR[k] * 2;
        localparam int HI = LO + 2;
        logic [CH_W-1:0] src;

        assign src = REG_IS_OPEN[k] ? det.open_det : det.short_det; // R1 R2

        flag_pair_reg u_flags (
            .clock  (clock),
            .rst_n  (rst_n),
            .lo_det (src[LO +: 2]), // R3 R4 R5 R6 R9
            .hi_det (src[HI +: 2]),
            .flag_q (flag_vec[k]),
            .rise   (rise_vec[k*EVT_PER +: EVT_PER])
        );
    end

    // ****************************************
    // address decode
    // ****************************************
    assign idx      = wb_req.adr[IDX_W+1:2];
    assign upper_ok = (wb_req.adr[ADR_W-1:IDX_W+2] == '0) && (wb_req.adr[1:0] == 2'h0);
    assign req      = wb_req.cyc && wb_req.stb;
    assign wr_fire  = req && wb_req.we && rsp_q.ack && upper_ok;

    for (genvar b = 0; b < EVT_W; b++) begin : g_wen
        assign wen[b] = wb_req.sel[b / BYTE_W];
    end

    // read mux, unmapped words read zero
    always_comb begin
        rd_d = '0;
        if (upper_ok) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                if (idx == REG_IDX[k*IDX_W +: IDX_W]) begin
                    rd_d[FLAG_W-1:0] = flag_vec[k]; // R4 R5 R6 R8 R10
                end
            end
            if (idx == IDX_EVT_STATUS) begin
                rd_d[EVT_W-1:0] = status;
            end
            if (idx == IDX_EVT_MASK) begin
                rd_d[EVT_W-1:0] = mask;
            end
        end
    end

    // ****************************************
    // bus answer
    // ****************************************
    always_comb begin
        rsp_d = rsp_q;
        if (rsp_q.ack) begin
            rsp_d.ack = 1'b0;
        end else if (req) begin
            rsp_d.ack = 1'b1;
            rsp_d.dat = wb_req.we ? '0 : rd_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign wb_rsp = rsp_q;

    // ****************************************
    // interrupt events
    // ****************************************
    sticky_event_bank #(
        .W (EVT_W)
    ) u_events (
        .clock     (clock),
        .rst_n     (rst_n),
        .set       (rise_vec),
        .wr_status (wr_fire && (idx == IDX_EVT_STATUS)),
        .wr_mask   (wr_fire && (idx == IDX_EVT_MASK)),
        .wdata     (wb_req.dat[EVT_W-1:0]),
        .wen       (wen),
        .status_q  (status),
        .mask_q    (mask),
        .irq_q     (irq_bank)
    );

    assign irq = irq_bank;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence rd_start(logic [IDX_W-1:0] at);
        req && !wb_req.we && !rsp_q.ack && upper_ok && (idx == at);
    endsequence

    sequence wr_done(logic [IDX_W-1:0] at);
        req && wb_req.we && rsp_q.ack && upper_ok && (idx == at);
    endsequence

    property read_returns(logic [IDX_W-1:0] at, int k);
        rd_start(at) |=> rsp_q.ack && (rsp_q.dat == {24'h000000, $past(flag_vec[k])});
    endproperty

    chk_open_gh_read: assert property (read_returns(IDX_OPEN_GH, K_OPEN_GH)) // R4
        else $error("open G/H flags not returned at their index");

    chk_short_ab_read: assert property (read_returns(IDX_SHORT_AB, K_SHORT_AB)) // R5
        else $error("short A/B flags not returned at their index");

    chk_short_cd_read: assert property (read_returns(IDX_SHORT_CD, K_SHORT_CD)) // R6
        else $error("short C/D flags not returned at their index");

    chk_short_ef_read: assert property (read_returns(IDX_SHORT_EF, K_SHORT_EF)) // R8
        else $error("short E/F flags not returned at their index");

    chk_open_ef_read: assert property (read_returns(IDX_OPEN_EF, K_OPEN_EF)) // R10
        else $error("open E/F flags not returned at their index");

    chk_open_follow: assert property ( // R1
        $rose(det.open_det[2*PAIR_G]) |=> flag_vec[K_OPEN_GH][LO_POS]
            ##1 (flag_vec[K_OPEN_GH][LO_POS] == $past(det.open_det[2*PAIR_G])))
        else $error("open flag does not follow its fault");

    chk_short_follow: assert property ( // R2
        $fell(det.short_det[2*PAIR_A+1]) |=> !flag_vec[K_SHORT_AB][LO_POS+1])
        else $error("short flag stays set after fault gone");

    chk_open_ef_map: assert property ( // R3
        flag_vec[K_OPEN_EF] == {2'h0, $past(det.open_det[2*PAIR_E+2 +: 2]),
                                2'h0, $past(det.open_det[2*PAIR_E +: 2])})
        else $error("open E/F bit placement wrong");

    chk_open_gh_map: assert property ( // R4
        flag_vec[K_OPEN_GH][HI_POS +: 2] == $past(det.open_det[2*PAIR_G+2 +: 2]))
        else $error("open H bits misplaced");

    chk_short_cd_map: assert property ( // R6
        flag_vec[K_SHORT_CD][HI_POS +: 2] == $past(det.short_det[2*PAIR_C+2 +: 2]))
        else $error("short D bits misplaced");

    chk_short_ef_map: assert property ( // R9
        flag_vec[K_SHORT_EF] == {2'h0, $past(det.short_det[2*PAIR_E+2 +: 2]),
                                 2'h0, $past(det.short_det[2*PAIR_E +: 2])})
        else $error("short E/F bit placement wrong");

    for (genvar k = 0; k < NUM_REGS; k++) begin : g_chk
        chk_reserved_zero: assert property ( // R7
            (flag_vec[k] & RSV_MASK) == FLAG_RESET)
            else $error("reserved flag bits not zero");
    end

    chk_reset_clear: assert property ( // R7
        disable iff (1'b0) !rst_n |=> (flag_vec == '0) && !rsp_q.ack && !irq)
        else $error("flags not zero after reset");

    chk_write_ignored: assert property ( // R11
        wr_done(IDX_SHORT_EF) |=>
            flag_vec[K_SHORT_EF] == {2'h0, $past(det.short_det[2*PAIR_E+2 +: 2]),
                                     2'h0, $past(det.short_det[2*PAIR_E +: 2])})
        else $error("bus write altered a flag");

    chk_ack_pulse: assert property (
        req && !rsp_q.ack |=> rsp_q.ack ##1 !rsp_q.ack)
        else $error("ack not a single cycle one cycle after request");

    chk_event_sticky: assert property (
        $rose(flag_vec[K_OPEN_EF][LO_POS]) |-> status[K_OPEN_EF*EVT_PER])
        else $error("new fault did not set its status bit");

    chk_irq_level: assert property (
        (status & mask) != '0 |-> irq)
        else $error("interrupt low with unmasked status set");

    // ****************************************
    // placement of the remaining pairs, and open E/F after a write
    // ****************************************
    // flags lag the detectors by one clock, so skip the clock after reset
    chk_open_gh_lo: assert property ( // R4
        $past(rst_n) |->
            flag_vec[K_OPEN_GH][LO_POS +: 2] == $past(det.open_det[2*PAIR_G +: 2]))
        else $error("open G bits misplaced");

    chk_short_ab_map: assert property ( // R5
        $past(rst_n) |->
            flag_vec[K_SHORT_AB] == {2'h0, $past(det.short_det[2*PAIR_A+2 +: 2]),
                                     2'h0, $past(det.short_det[2*PAIR_A +: 2])})
        else $error("short A/B bit placement wrong");

    chk_short_cd_lo: assert property ( // R6
        $past(rst_n) |->
            flag_vec[K_SHORT_CD][LO_POS +: 2] == $past(det.short_det[2*PAIR_C +: 2]))
        else $error("short C bits misplaced");

    chk_open_ef_write: assert property ( // R11
        wr_done(IDX_OPEN_EF) |=>
            flag_vec[K_OPEN_EF] == {2'h0, $past(det.open_det[2*PAIR_E+2 +: 2]),
                                    2'h0, $past(det.open_det[2*PAIR_E +: 2])})
        else $error("bus write altered an open flag");

    // ****************************************
    // bus answer details
    // ****************************************
    sequence wr_start;
        req && wb_req.we && !rsp_q.ack;
    endsequence

    sequence rd_unmapped;
        req && !wb_req.we && !rsp_q.ack && (idx > IDX_EVT_MASK);
    endsequence

    chk_write_answer: assert property (
        wr_start |=> rsp_q.ack && (rsp_q.dat == '0))
        else $error("write answer carries data");

    chk_unmapped_zero: assert property (
        rd_unmapped |=> rsp_q.ack && (rsp_q.dat == '0))
        else $error("unmapped word does not read zero");

    chk_ack_cause: assert property (
        $rose(rsp_q.ack) |-> $past(req))
        else $error("ack without a request");

    chk_data_stands: assert property (
        rst_n && !(req && !rsp_q.ack) |=> $stable(rsp_q.dat))
        else $error("read data changed without a new access");

    // ****************************************
    // interrupt bank
    // ****************************************
    // rst_n in the antecedents keeps the release edge, still in reset, out
    sequence new_event;
        rst_n && (rise_vec != '0);
    endsequence

    sequence status_write;
        rst_n && wr_fire && (idx == IDX_EVT_STATUS) && (wb_req.sel == 4'hF);
    endsequence

    sequence mask_write;
        rst_n && wr_fire && (idx == IDX_EVT_MASK) && (wb_req.sel == 4'hF);
    endsequence

    chk_set_wins: assert property (
        new_event |=> (status & $past(rise_vec)) == $past(rise_vec))
        else $error("new fault event lost");

    chk_status_clear: assert property (
        status_write |=> (status & $past(wb_req.dat[EVT_W-1:0] & ~rise_vec)) == '0)
        else $error("write one did not clear status");

    chk_status_hold: assert property (
        rst_n && (rise_vec == '0)
            && !(wr_fire && (idx == IDX_EVT_STATUS))
            |=> $stable(status))
        else $error("status changed without event or clear");

    chk_mask_write: assert property (
        mask_write |=> mask == $past(wb_req.dat[EVT_W-1:0]))
        else $error("mask write not stored");

    chk_mask_hold: assert property (
        rst_n && !(wr_fire && (idx == IDX_EVT_MASK)) |=> $stable(mask))
        else $error("mask changed without a write");

    chk_irq_quiet: assert property (
        (status & mask) == '0 |-> !irq)
        else $error("interrupt high with no unmasked status");

endmodule

// File: flag_pair_reg.sv
`timescale 1ns/1ps
module flag_pair_reg
    import fault_flag_pkg::*;
(
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst_n,
    // live fault indications of the two pairs
    input  wire logic [1:0]          lo_det,
    input  wire logic [1:0]          hi_det,
    // register image and new-fault pulses
    output logic [FLAG_W-1:0]        flag_q,
    output logic [EVT_PER-1:0]       rise
);

    logic [FLAG_W-1:0] flag_d;

    // ****************************************
    // packing, reserved bits stay zero
    // ****************************************
    always_comb begin
        flag_d = FLAG_RESET; // R7
        flag_d[LO_POS +: 2] = lo_det; // R1 R2
        flag_d[HI_POS +: 2] = hi_det;
    end

    // only the diagnostic inputs load the flags
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag_q <= FLAG_RESET; // R7
        end else begin
            flag_q <= flag_d; // R11
        end
    end

    assign rise = {flag_d[HI_POS +: 2] & ~flag_q[HI_POS +: 2],
                   flag_d[LO_POS +: 2] & ~flag_q[LO_POS +: 2]};

endmodule

// File: sticky_event_bank.sv
`timescale 1ns/1ps
module sticky_event_bank
    import fault_flag_pkg::*;
#(
    parameter int W = EVT_W
)
(
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // events and software writes
    input  wire logic [W-1:0] set,
    input  wire logic         wr_status,
    input  wire logic         wr_mask,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] wen,
    // state
    output logic [W-1:0]      status_q,
    output logic [W-1:0]      mask_q,
    output logic              irq_q
);

    logic [W-1:0] status_d;
    logic [W-1:0] mask_d;

    // set wins over a write-one clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_q & ~(wdata & wen);
        end
        status_d = status_d | set;
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = (mask_q & ~wen) | (wdata & wen);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status_q <= '0;
            mask_q   <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            irq_q    <= |(status_d & mask_d);
        end
    end

endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb
    import fault_flag_pkg::*;
;
    // ****************************************
    // clock, reset and design
    // ****************************************
    logic          clock = 1'b0;
    logic          rst_n = 1'b0;
    wb_req_type    req   = '0;
    wb_rsp_type    rsp;
    fault_det_type det   = '0;
    logic          irq;
    int            n_fail     = 0;
    int            num_checks = 0;
    logic [31:0]   rd;

    typedef struct packed {
        logic [15:0] o;
        logic [15:0] s;
        logic [39:0] e;
    } row_type;

    // expected bytes in slot order: open ef, open gh, short ab, short cd, short ef
    localparam row_type ROWS [4] = '{
        '{16'hFFFF, 16'hFFFF, 40'h3333333333},
        '{16'h0500, 16'h00A0, 40'h1100002200},
        '{16'hA000, 16'h0A05, 40'h0022110022},
        '{16'h0000, 16'h0000, 40'h0000000000}
    };

    always #2 clock = ~clock;

    fault_flag_regs uut (
        .clock  (clock),
        .rst_n  (rst_n),
        .wb_req (req),
        .wb_rsp (rsp),
        .det    (det),
        .irq    (irq)
    );

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic end_of_test;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    // ****************************************
    // wishbone classic single cycle
    // ****************************************
    task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock);
        req.cyc <= 1'b1;
        req.stb <= 1'b1;
        req.we  <= w;
        req.adr <= {22'h000000, idx, 2'h0};
        req.sel <= 4'hF;
        req.dat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        r = rsp.dat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        if (n >= 50) begin
            n_fail++;
            end_of_test();
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        idle(3);
        rst_n <= 1'b1;
        for (int k = 0; k < NUM_REGS; k++) begin
            wb(1'b0, REG_IDX[k*IDX_W +: IDX_W], 32'h0, rd);
            chk("flag after reset", 32'h00000000, rd);
        end
        chk_bit("irq after reset", 1'b0, irq);
        // table of detector patterns against register images
        foreach (ROWS[i]) begin
            @(posedge clock);
            det.open_det  <= ROWS[i].o;
            det.short_det <= ROWS[i].s;
            idle(2);
            for (int k = 0; k < NUM_REGS; k++) begin
                wb(1'b0, REG_IDX[k*IDX_W +: IDX_W], 32'h0, rd);
                chk("flag image", {24'h0, ROWS[i].e[39-8*k -: 8]}, rd);
            end
        end
        // writes to flags are dropped, both with flags low and high
        wb(1'b1, IDX_OPEN_EF, 32'h000000FF, rd);
        wb(1'b0, IDX_OPEN_EF, 32'h0, rd);
        chk("flag after write", 32'h00000000, rd);
        @(posedge clock);
        det.short_det <= 16'hFFFF;
        idle(2);
        wb(1'b1, IDX_SHORT_EF, 32'h00000000, rd);
        wb(1'b0, IDX_SHORT_EF, 32'h0, rd);
        chk("flag after clear write", 32'h00000033, rd);
        // unmapped word reads zero
        wb(1'b0, 8'hFF, 32'h0, rd);
        chk("unmapped read", 32'h00000000, rd);
        // interrupt: clear, unmask, raise, clear again
        @(posedge clock);
        det.short_det <= 16'h0000;
        idle(2);
        wb(1'b1, IDX_EVT_STATUS, 32'h000FFFFF, rd);
        wb(1'b1, IDX_EVT_MASK, 32'h00000001, rd);
        wb(1'b0, IDX_EVT_MASK, 32'h0, rd);
        chk("mask readback", 32'h00000001, rd);
        wb(1'b0, IDX_EVT_STATUS, 32'h0, rd);
        chk("status cleared", 32'h00000000, rd);
        chk_bit("irq idle", 1'b0, irq);
        @(posedge clock);
        det.open_det <= 16'h0100;
        det.short_det <= 16'h0001;
        idle(3);
        chk_bit("irq raised", 1'b1, irq);
        wb(1'b0, IDX_EVT_STATUS, 32'h0, rd);
        chk("status set", 32'h00000101, rd);
        @(posedge clock);
        det.open_det <= 16'h0000;
        idle(3);
        chk_bit("irq held", 1'b1, irq);
        wb(1'b1, IDX_EVT_STATUS, 32'h00000001, rd);
        idle(2);
        chk_bit("irq cleared", 1'b0, irq);
        wb(1'b0, IDX_EVT_STATUS, 32'h0, rd);
        chk("status after clear", 32'h00000100, rd);
        wb(1'b0, IDX_SHORT_AB, 32'h0, rd);
        chk("short a first", 32'h00000001, rd);
        // reset in mid-run with faults present
        @(posedge clock);
        rst_n <= 1'b0;
        idle(3);
        chk_bit("irq in reset", 1'b0, irq);
        rst_n <= 1'b1;
        // short A fault is still present, so its flag rises again out of reset
        wb(1'b0, IDX_EVT_STATUS, 32'h0, rd);
        chk("status after reset", 32'h00000100, rd);
        wb(1'b0, IDX_EVT_MASK, 32'h0, rd);
        chk("mask after reset", 32'h00000000, rd);
        chk_bit("irq masked after reset", 1'b0, irq);
        wb(1'b0, IDX_SHORT_AB, 32'h0, rd);
        chk("short a after reset", 32'h00000001, rd);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        end_of_test();
    end
endmodule
